// *** verilog/mbp_pkg.sv ***
package mbp_pkg;

   // ----------------------------------------------------------------
   // Register map (APB byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PULSE = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_DMA = 8'h10;
   localparam logic [7:0] OFF_SCRATCH = 8'h14;

   // ----------------------------------------------------------------
   // Fields
   // ----------------------------------------------------------------
   localparam int CTRL_LEVEL_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int ST_IRQ_BIT = 0;
   localparam int ST_DMA_BIT = 1;
   localparam int DMA_REQ_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [7:0] RST_PULSE = 8'h02;
   localparam logic [7:0] MIN_PULSE = 8'h02;
   localparam logic [7:0] LEVEL_MIN_CYC = 8'h02;
   localparam logic [1:0] DEMAND_CYC = 2'h3;
   localparam logic [1:0] WAIT_SLOW = 2'h1;

   typedef enum logic [1:0] {
      DMA_BLOCK,
      DMA_STEP,
      DMA_BURST,
      DMA_DEMAND
   } mbp_dma_mode_t;

   typedef struct packed {
      logic level_mode;
      mbp_dma_mode_t dma_mode;
   } mbp_cfg_t;

endpackage

// *** verilog/mbp_port.sv ***
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Operation
// RULE1: Every access takes at least one clock; length by address; ready ends it.
// RULE2: Host holds the access open until ready is asserted.
// RULE3: Host may end the access in the cycle ready is seen.
// RULE4: Edge mode irq pulse lasts the programmed number of clock periods.
// RULE5: Level mode irq stays asserted at least two clock cycles.
// RULE6: Block, step, burst modes: request updates one cycle after acknowledge.
// RULE7: Demand mode: request reacts to acknowledge after at least three cycles.
// RULE8: Far side changes acknowledge high-to-low only between clock edges.
// RULE9: Read data is valid no later than the cycle ready is asserted.
module mbp_port
   import mbp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Device events and DMA
   input wire logic irq_event,
   input wire logic dma_acknowledge,
   // Device pins
   output logic irq_out,
   output logic dma_request,
   output logic irq_line
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFF_CTRL) || (a == OFF_PULSE) || (a == OFF_STATUS) ||
               (a == OFF_MASK) || (a == OFF_DMA) || (a == OFF_SCRATCH);
   endfunction

   // Status and scratch take one wait cycle
   function automatic logic slow_addr(input logic [7:0] a);
      slow_addr = (a == OFF_STATUS) || (a == OFF_SCRATCH);
   endfunction

   mbp_cfg_t cfg, next_cfg;
   logic [7:0] irq_pulse_width_setting, next_pulse;
   logic [1:0] status, next_status;
   logic [1:0] mask, next_mask;
   logic [31:0] scratch, next_scratch;
   logic dma_enable, next_dma_enable;
   logic [1:0] wait_cnt, next_wait_cnt;
   logic [31:0] next_prdata;
   logic access, done;

   assign access = psel && penable;
   // RULE1: wait-state ready
   assign done = access && (!slow_addr(paddr) || (wait_cnt == WAIT_SLOW));
   assign pready = done;
   assign pslverr = done && !mapped(paddr);

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   always_comb
   begin
      next_cfg = cfg;
      next_pulse = irq_pulse_width_setting;
      next_mask = mask;
      next_scratch = scratch;
      next_dma_enable = dma_enable;
      next_status = status;
      next_prdata = prdata;
      next_wait_cnt = (access && !done) ? wait_cnt + 2'h1 : 2'h0;
      // Preload in setup and wait cycles so data stands with pready
      if (psel && !pwrite && !done)
      begin
         // RULE9: data before ready
         case (paddr)
            OFF_CTRL: next_prdata = {29'h0, cfg.dma_mode, cfg.level_mode};
            OFF_PULSE: next_prdata = {24'h0, irq_pulse_width_setting};
            OFF_STATUS: next_prdata = {30'h0, status};
            OFF_MASK: next_prdata = {30'h0, mask};
            OFF_DMA: next_prdata = {30'h0, dma_request, dma_enable};
            OFF_SCRATCH: next_prdata = scratch;
            default: next_prdata = 32'h0;
         endcase
      end
      // Clear only bits the read returned, so no event is lost
      if (done && !pwrite && paddr == OFF_STATUS)
         next_status = status & ~prdata[1:0];
      if (done && pwrite)
      begin
         case (paddr)
            OFF_CTRL:
            begin
               next_cfg.level_mode = pwdata[CTRL_LEVEL_BIT];
               next_cfg.dma_mode =
                  mbp_dma_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            end
            // Below two would break the edge-mode minimum
            OFF_PULSE: next_pulse = (pwdata[7:0] < MIN_PULSE) ?
                                    MIN_PULSE : pwdata[7:0];
            OFF_MASK: next_mask = pwdata[1:0];
            OFF_DMA: next_dma_enable = pwdata[DMA_REQ_BIT];
            OFF_SCRATCH: next_scratch = pwdata;
            default: next_scratch = scratch;
         endcase
      end
      // Set wins over the read clear
      if (irq_event)
         next_status[ST_IRQ_BIT] = 1'b1;
      if (dma_acknowledge && !dma_request)
         next_status[ST_DMA_BIT] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= mbp_cfg_t'(RST_CTRL[2:0]);
         irq_pulse_width_setting <= RST_PULSE;
         mask <= 2'h0;
         status <= 2'h0;
         scratch <= 32'h0;
         dma_enable <= 1'b0;
         wait_cnt <= 2'h0;
         prdata <= 32'h0;
      end
      else
      begin
         cfg <= next_cfg;
         irq_pulse_width_setting <= next_pulse;
         mask <= next_mask;
         status <= next_status;
         scratch <= next_scratch;
         dma_enable <= next_dma_enable;
         wait_cnt <= next_wait_cnt;
         prdata <= next_prdata;
      end
   end

   assign irq_line = |(status & mask);

   // ----------------------------------------------------------------
   // Interrupt pin shaping
   // ----------------------------------------------------------------
   logic [7:0] irq_cnt, next_irq_cnt;
   logic next_irq_out, irq_prev, src;
   assign src = irq_event;
   always_comb
   begin
      next_irq_out = irq_out;
      next_irq_cnt = irq_cnt;
      if (irq_out)
      begin
         if (irq_cnt != 8'h0)
            next_irq_cnt = irq_cnt - 8'h1;
         // RULE4: programmed pulse
         if (!cfg.level_mode && irq_cnt == 8'h1)
            next_irq_out = 1'b0;
         // RULE5: level minimum hold
         if (cfg.level_mode && irq_cnt <= 8'h1 && !src)
            next_irq_out = 1'b0;
      end
      else if (src && !irq_prev)
      begin
         next_irq_out = 1'b1;
         next_irq_cnt = cfg.level_mode ? LEVEL_MIN_CYC :
                        irq_pulse_width_setting;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_out <= 1'b0;
         irq_cnt <= 8'h0;
         irq_prev <= 1'b0;
      end
      else
      begin
         irq_out <= next_irq_out;
         irq_cnt <= next_irq_cnt;
         irq_prev <= src;
      end
   end

   // ----------------------------------------------------------------
   // DMA request
   // ----------------------------------------------------------------
   // Only rising-edge sampling; a falling-edge stage is not needed here
   logic [1:0] dly, next_dly;
   logic next_dma_request;

   always_comb
   begin
      next_dly = 2'h0;
      next_dma_request = dma_enable;
      if (cfg.dma_mode == DMA_DEMAND)
      begin
         // RULE7: three-cycle reaction
         next_dly = dly;
         next_dma_request = dma_request;
         if (dma_acknowledge && dma_request)
         begin
            next_dly = (dly == DEMAND_CYC - 2'h1) ? dly : dly + 2'h1;
            if (dly == DEMAND_CYC - 2'h1)
               next_dma_request = 1'b0;
         end
         else
         begin
            next_dly = 2'h0;
            if (!dma_acknowledge)
               next_dma_request = dma_enable;
         end
      end
      else
         // RULE6: one-cycle reaction
         next_dma_request = dma_enable && !dma_acknowledge;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dly <= 2'h0;
         dma_request <= 1'b0;
      end
      else
      begin
         dly <= next_dly;
         dma_request <= next_dma_request;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_slow_wait;
      access && slow_addr(paddr) && !pready ##1 pready;
   endsequence
   property p_slow_access;
      @(posedge pclk) disable iff (!presetn)
      $rose(access) && slow_addr(paddr) |-> s_slow_wait;
   endproperty
   a_slow_access: assert property (p_slow_access) // RULE1
      else $error("slow access not one wait");
   property p_ready_access;
      @(posedge pclk) disable iff (!presetn)
      pready |-> $past(psel);
   endproperty
   a_ready_access: assert property (p_ready_access) // RULE1
      else $error("ready without a setup cycle");
   property p_read_data;
      @(posedge pclk) disable iff (!presetn)
      pready && !pwrite && paddr == OFF_SCRATCH |-> prdata == scratch;
   endproperty
   a_read_data: assert property (p_read_data) // RULE9
      else $error("read data wrong");
   property p_edge_pulse;
      @(posedge pclk) disable iff (!presetn)
      $rose(irq_out) && !cfg.level_mode && irq_pulse_width_setting == 8'h2
      |-> irq_out[*2] ##1 !irq_out;
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) // RULE4
      else $error("edge pulse width wrong");
   property p_level_min;
      @(posedge pclk) disable iff (!presetn)
      $rose(irq_out) && cfg.level_mode |-> irq_out[*2];
   endproperty
   a_level_min: assert property (p_level_min) // RULE5
      else $error("level irq too short");
   property p_dma_one;
      @(posedge pclk) disable iff (!presetn)
      cfg.dma_mode != DMA_DEMAND && $stable(cfg) && $past(cfg) == cfg
      |-> dma_request == $past(dma_enable && !dma_acknowledge);
   endproperty
   a_dma_one: assert property (p_dma_one) // RULE6
      else $error("dma request not one cycle");
   property p_dma_demand;
      @(posedge pclk) disable iff (!presetn)
      cfg.dma_mode == DMA_DEMAND && $fell(dma_request) && $past(dma_enable)
      |-> $past(dma_acknowledge, 3) && $past(dma_acknowledge, 1);
   endproperty
   a_dma_demand: assert property (p_dma_demand) // RULE7
      else $error("demand drop too early");
   property p_irq_line;
      @(posedge pclk) disable iff (!presetn)
      irq_event && mask[ST_IRQ_BIT] |=> irq_line;
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt line missed");

endmodule

// *** dv/mbp_dma_host.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host DMA controller model
// ----------------------------------------------------------------
module mbp_dma_host
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Handshake
   input wire logic [3:0] delay,
   input wire logic dma_request,
   output logic dma_acknowledge
);
   int cnt;
   always @(pclk or negedge presetn)
      if (!presetn)
      begin
         cnt = 0;
         dma_acknowledge <= 1'b0;
      end
      else if (pclk)
      begin
         // Delay lets the model answer promptly or slowly
         cnt = dma_request ? cnt + 1 : 0;
         if (cnt > delay)
            dma_acknowledge <= 1'b1;
      end
      else if (!dma_request)
         dma_acknowledge <= 1'b0;
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench
// ----------------------------------------------------------------
module testbench;
   import mbp_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, irq_event = 1'b0, en = 1'b0;
   logic pready, pslverr, ack, req, irq_out, irq_line, ack_s, req_s;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h01a88fda;
   logic [3:0] dly = 4'h0;
   logic [1:0] mode = 2'h0;
   logic [32:0] q[$];
   int error_cnt = 0, compares = 0, cyc = 0, n, dcnt = 0;

   mbp_port i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq_event,
      .dma_acknowledge(ack), .irq_out, .dma_request(req), .irq_line);
   mbp_dma_host i_host (.pclk, .presetn, .delay(dly),
      .dma_request(req), .dma_acknowledge(ack));

   initial forever #25 pclk = ~pclk;

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(string nm, logic [32:0] s, logic [32:0] e);
      compares++;
      if (s !== e)
      begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic finish_test();
      if (error_cnt == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Waits on pready, then checks the counted wait cycles against ew
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d, int ew);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
      begin
         k++;
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      check("waits", 33'(k), 33'(ew));
   endtask

   task automatic rd(logic [7:0] a, logic [32:0] e, int ew);
      q.push_back(e);
      apb(1'b0, a, 32'h0, ew);
   endtask

   task automatic pulse(int ew);
      int k;
      k = 0;
      irq_event <= 1'b1;
      @(posedge pclk);
      irq_event <= 1'b0;
      // First sample follows the edge that raises the pin
      for (int i = 0; i < 40; i++)
      begin
         #1;
         if (irq_out === 1'b1)
            k++;
         @(posedge pclk);
      end
      check("irq_width", 33'(k), 33'(ew));
   endtask

   // ----------------------------------------------------------------
   // Monitors
   // ----------------------------------------------------------------
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite && q.size() > 0)
         check("read", {pslverr, prdata}, q.pop_front());

   always @(posedge pclk)
   begin
      ack_s = ack;
      req_s = req;
      #1;
      if (en)
      begin
         dcnt = (ack_s && req_s) ? dcnt + 1 : 0;
         if (mode != 2'h3)
            check("dreq", 33'(req), 33'(!ack_s));
         else if (dcnt > 0)
            check("dreq_demand", 33'(req), 33'(dcnt < 3));
      end
      else
         dcnt = 0;
   end

   // Hang guard, far above the few hundred cycles needed
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc > 5000)
      begin
         error_cnt++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(OFF_CTRL, 33'h0, 0);
      rd(OFF_PULSE, {25'h0, RST_PULSE}, 0);
      rd(OFF_STATUS, 33'h0, 1);
      rd(8'h18, 33'h1_0000_0000, 0);
      apb(1'b1, OFF_PULSE, 32'h1, 0);
      rd(OFF_PULSE, {25'h0, MIN_PULSE}, 0);
      pulse(MIN_PULSE);
      r = $random(seed);
      apb(1'b1, OFF_SCRATCH, r, 1);
      rd(OFF_SCRATCH, {1'b0, r}, 1);
      n = 3 + r[2:0];
      apb(1'b1, OFF_PULSE, 32'(n), 0);
      pulse(n);
      check("irq_line", 33'(irq_line), 33'h0);
      rd(OFF_STATUS, 33'h1, 1);
      rd(OFF_STATUS, 33'h0, 1);
      apb(1'b1, OFF_MASK, 32'h1, 0);
      apb(1'b1, OFF_CTRL, 32'h1, 0);
      pulse(LEVEL_MIN_CYC);
      check("irq_line", 33'(irq_line), 33'h1);
      rd(OFF_STATUS, 33'h1, 1);
      check("irq_line", 33'(irq_line), 33'h0);
      // Every DMA mode, host answering at a random pace
      for (int m = 0; m < 4; m++)
      begin
         mode = m[1:0];
         r = $random(seed);
         dly <= r[3:0];
         apb(1'b1, OFF_CTRL, {29'h0, mode, 1'b0}, 0);
         apb(1'b1, OFF_DMA, 32'h1, 0);
         en = 1'b1;
         repeat (60) @(posedge pclk);
         en = 1'b0;
         apb(1'b1, OFF_DMA, 32'h0, 0);
      end
      finish_test();
   end
endmodule
